// file: hw/sfe_pkg.sv
package sfe_pkg;
   localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
   localparam logic [7:0] OP_FULL_BLOCK_ERASE = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
   localparam logic [7:0] OP_MAKER_DEVICE_ID_READ = 8'h90;
   localparam logic [7:0] OP_IDENTIFICATION_READ = 8'h9f;
   localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4b;
   localparam logic [7:0] OP_SECURE_ERASE = 8'h44;
   localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int OPCODE_BITS = 8;
   localparam int ADDR_END_BITS = 32;
   localparam int UID_START_BITS = 40;
   localparam int SECURE_REG_BYTES = 1024;
   localparam int SECURE_REG_COUNT = 3;
   localparam int CLK_MHZ = 200;
   localparam int HALF_BLOCK_ERASE_TIME_US = 150000;
   localparam int FULL_BLOCK_ERASE_TIME_US = 200000;
   localparam int CHIP_ERASE_TIME_US = 20000000;
   localparam int SECTOR_ERASE_TIME_US = 45000;
   localparam longint HALF_BLOCK_ERASE_CYCLES = longint'(HALF_BLOCK_ERASE_TIME_US) * CLK_MHZ;
   localparam longint FULL_BLOCK_ERASE_CYCLES = longint'(FULL_BLOCK_ERASE_TIME_US) * CLK_MHZ;
   localparam longint CHIP_ERASE_CYCLES = longint'(CHIP_ERASE_TIME_US) * CLK_MHZ;
   localparam longint SECTOR_ERASE_CYCLES = longint'(SECTOR_ERASE_TIME_US) * CLK_MHZ;
   localparam logic [3:0] ERASE_HALF = 4'h1;
   localparam logic [3:0] ERASE_FULL = 4'h2;
   localparam logic [3:0] ERASE_CHIP = 4'h4;
   localparam logic [3:0] ERASE_SECURE = 4'h8;
   typedef struct packed {
      logic [4:0] blockProtect;
      logic protectComplement;
      logic [2:0] secureRegLock;
   } sfe_prot_t;
   typedef struct packed {
      logic writeInProgress;
      logic writeEnableLatch;
   } sfe_status_t;
   typedef struct packed {
      logic go;
      logic [3:0] kind;
      logic [23:0] base;
      logic [1:0] secureSel;
   } sfe_erase_t;
endpackage

// file: hw/sfe_erase_timer.sv
`timescale 1ns/10ps
module sfe_erase_timer
   import sfe_pkg::*;
#(
   parameter longint HALF_CYC = HALF_BLOCK_ERASE_CYCLES,
   parameter longint FULL_CYC = FULL_BLOCK_ERASE_CYCLES,
   parameter longint CHIP_CYC = CHIP_ERASE_CYCLES,
   parameter longint SECT_CYC = SECTOR_ERASE_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   input wire logic [3:0] kind,
   output logic busy,
   output logic done
);
   logic [39:0] count;
   logic [39:0] next_count;
   logic next_busy;
   logic next_done;
   function automatic logic [39:0] cyclesFor(input logic [3:0] k);
      if (k == ERASE_HALF) begin
         return HALF_CYC[39:0];
      end else if (k == ERASE_FULL) begin
         return FULL_CYC[39:0];
      end else if (k == ERASE_CHIP) begin
         return CHIP_CYC[39:0];
      end else begin
         return SECT_CYC[39:0];
      end
   endfunction
   always_comb begin
      next_count = count;
      next_busy = busy;
      next_done = 1'b0;
      if (start && !busy) begin
         next_count = cyclesFor(kind) - 40'h1;
         next_busy = 1'b1;
      end else if (busy) begin
         if (count == 40'h0) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end else begin
            next_count = count - 40'h1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         count <= 40'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         count <= next_count;
         busy <= next_busy;
         done <= next_done;
      end
   end
endmodule

// file: hw/sfe_flash_cmd.sv
`timescale 1ns/10ps
// Overview of operation
// - opcode 52h plus 24-bit address erases the 32KB block holding that address
// - opcode D8h plus 24-bit address erases the 64KB block holding that address
// - opcodes 60h and C7h both erase the chip, opcode only
// - block and secure erases run only if deselect follows bit 32 exactly
// - chip erase runs only if deselect follows bit 8 exactly
// - valid erase starts a self-timed cycle with its own duration at deselect
// - write in progress is 1 during the cycle, 0 after; status readable
// - write enable latch cleared as the erase cycle ends, on the same clock as write in progress drops
// - erase of a protected block is dropped and the latch cleared
// - chip erase only with protect bits 2-0 all 0/complement 0 or all 1/complement 1
// - 90h plus zero address returns maker id then device id, msb first
// - 9Fh returns maker code, memory type, capacity on falling edges
// - identification read during a busy cycle is not decoded
// - raising chip select ends any id output; device returns to standby
// - 4Bh, zero address, dummy byte, then a 128-bit unique id
// - three 1024-byte secure registers erased by 44h with sector erase time
// - secure address: 23-16 zero, 15-12 picks 1..3, 11-10 zero, 9-0 ignored
// - locked secure register erase is ignored and the latch cleared
module sfe_flash_cmd
   import sfe_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'h5a,
   parameter logic [7:0] DEVICE_ID = 8'h33,
   parameter logic [7:0] MEM_TYPE = 8'h61,
   parameter logic [7:0] CAPACITY = 8'h17,
   parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210,
   parameter logic [6:0] SEC_ADDR_BITS = 7'd6,
   parameter longint HALF_CYC = HALF_BLOCK_ERASE_CYCLES,
   parameter longint FULL_CYC = FULL_BLOCK_ERASE_CYCLES,
   parameter longint CHIP_CYC = CHIP_ERASE_CYCLES,
   parameter longint SECT_CYC = SECTOR_ERASE_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic csN,
   input wire logic sclk,
   input wire logic si,
   input wire logic [8:0] protIn,
   input wire logic [7:0] readAddr,
   output logic so,
   output logic soEn,
   output logic writeInProgress,
   output logic writeEnableLatch,
   output logic [23:0] eraseBase,
   output logic [3:0] eraseKind,
   output logic erasePulse,
   output logic [7:0] readByte
);
   // idle/shifting/output states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_IN = 3'b010,
      ST_OUT = 3'b100
   } sfe_state_t;
   sfe_prot_t prot;
   assign prot = protIn;
   logic [2:0] csSync, sclkSync;
   logic [1:0] siSync;
   logic [2:0] next_csSync, next_sclkSync;
   logic [1:0] next_siSync;
   always_comb begin
      next_csSync = {csSync[1:0], csN};
      next_sclkSync = {sclkSync[1:0], sclk};
      next_siSync = {siSync[0], si};
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         csSync <= 3'b111;
         sclkSync <= 3'b000;
         siSync <= 2'b00;
      end else begin
         csSync <= next_csSync;
         sclkSync <= next_sclkSync;
         siSync <= next_siSync;
      end
   end
   logic csLow, csRise, csFall, sRise, sFall;
   assign csLow = !csSync[1];
   assign csRise = csSync[1] && !csSync[2];
   assign csFall = !csSync[1] && csSync[2];
   assign sRise = sclkSync[1] && !sclkSync[2];
   assign sFall = !sclkSync[1] && sclkSync[2];

   sfe_state_t state, next_state;
   logic [6:0] bitCnt, next_bitCnt;
   logic [31:0] shiftIn, next_shiftIn;
   logic [7:0] opcode, next_opcode;
   logic [127:0] outReg, next_outReg;
   logic next_so, next_soEn, next_wel, next_erasePulse;
   logic [23:0] next_eraseBase;
   logic [3:0] next_eraseKind;
   logic [7:0] next_readByte;
   logic [2:0] erasedSec, next_erasedSec;
   logic timerStart;
   logic [3:0] timerKind;
   logic busy, done;

   function automatic logic blockProtected(input logic [23:0] a, input sfe_prot_t p);
      // simplified map: nonzero protect bits 2-0 guard the top region unless complemented
      logic hit;
      hit = 1'b0;
      if (p.blockProtect[2:0] != 3'b000) begin
         hit = (a[22:20] >= (3'd7 - p.blockProtect[2:0] + 3'd1));
         if (p.protectComplement) begin
            hit = !hit;
         end
      end else if (p.protectComplement) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   function automatic logic chipAllowed(input sfe_prot_t p);
      return (p.blockProtect[2:0] == 3'b000 && !p.protectComplement) ||
             (p.blockProtect[2:0] == 3'b111 && p.protectComplement);
   endfunction

   always_comb begin
      next_state = state;
      next_bitCnt = bitCnt;
      next_shiftIn = shiftIn;
      next_opcode = opcode;
      next_outReg = outReg;
      next_so = so;
      next_soEn = soEn;
      next_wel = writeEnableLatch;
      next_erasePulse = 1'b0;
      next_eraseBase = eraseBase;
      next_eraseKind = eraseKind;
      next_erasedSec = erasedSec;
      next_readByte = erasedSec[readAddr[1:0] == 2'd0 ? 0 : 2'(readAddr[1:0] - 2'd1)] ? ERASED_BYTE : 8'h00;
      timerStart = 1'b0;
      timerKind = ERASE_SECURE;
      if (done) begin
         next_wel = 1'b0;
      end
      case (state)
         ST_IDLE: begin
            if (csFall) begin
               next_state = ST_IN;
               next_bitCnt = 7'd0;
               next_opcode = 8'h00;
            end
         end
         ST_IN: begin
            if (csRise) begin
               next_state = ST_IDLE;
               if (!busy && bitCnt == 7'(OPCODE_BITS) && opcode == OP_WRITE_ENABLE_CMD) begin
                  next_wel = 1'b1;
               end else if (!busy && writeEnableLatch) begin
                  if ((opcode == OP_CHIP_ERASE_A || opcode == OP_CHIP_ERASE_B) &&
                      bitCnt == 7'(OPCODE_BITS)) begin
                     if (chipAllowed(prot)) begin
                        timerStart = 1'b1;
                        timerKind = ERASE_CHIP;
                        next_eraseBase = 24'h0;
                        next_erasedSec = 3'b000;
                     end else begin
                        next_wel = 1'b0;
                     end
                  end else if ((opcode == OP_HALF_BLOCK_ERASE || opcode == OP_FULL_BLOCK_ERASE) &&
                               bitCnt == 7'(ADDR_END_BITS)) begin
                     if (blockProtected(shiftIn[23:0], prot)) begin
                        next_wel = 1'b0;
                     end else if (opcode == OP_HALF_BLOCK_ERASE) begin
                        timerStart = 1'b1;
                        timerKind = ERASE_HALF;
                        next_eraseBase = {shiftIn[23:15], 15'h0};
                     end else begin
                        timerStart = 1'b1;
                        timerKind = ERASE_FULL;
                        next_eraseBase = {shiftIn[23:16], 16'h0};
                     end
                  end else if (opcode == OP_SECURE_ERASE && bitCnt == 7'(ADDR_END_BITS) &&
                               shiftIn[23:16] == 8'h00 && shiftIn[11:10] == 2'b00 &&
                               shiftIn[15:12] >= 4'h1 && shiftIn[15:12] <= 4'(SECURE_REG_COUNT)) begin
                     if (prot.secureRegLock[2'(shiftIn[13:12] - 2'd1)]) begin
                        next_wel = 1'b0;
                     end else begin
                        timerStart = 1'b1;
                        timerKind = ERASE_SECURE;
                        next_eraseBase = {shiftIn[23:10], 10'h0};
                        next_erasedSec[2'(shiftIn[13:12] - 2'd1)] = 1'b1;
                     end
                  end
               end
               if (timerStart) begin
                  next_erasePulse = 1'b1;
                  next_eraseKind = timerKind;
               end
            end else if (sRise) begin
               next_shiftIn = {shiftIn[30:0], siSync[1]};
               next_bitCnt = bitCnt + 7'd1;
               if (bitCnt == 7'(OPCODE_BITS - 1)) begin
                  next_opcode = {shiftIn[6:0], siSync[1]};
                  if ({shiftIn[6:0], siSync[1]} == OP_IDENTIFICATION_READ && !busy) begin
                     next_state = ST_OUT;
                     next_outReg = {MAKER_ID, MEM_TYPE, CAPACITY, 104'h0};
                  end
               end
               if (bitCnt == 7'(ADDR_END_BITS - 1) && opcode == OP_MAKER_DEVICE_ID_READ) begin
                  next_state = ST_OUT;
                  next_outReg = {MAKER_ID, DEVICE_ID, 112'h0};
               end
               if (bitCnt == 7'(UID_START_BITS - 1) && opcode == OP_UNIQUE_ID_READ) begin
                  next_state = ST_OUT;
                  next_outReg = UNIQUE_ID;
               end
            end
         end
         ST_OUT: begin
            if (csRise) begin
               next_state = ST_IDLE;
               next_soEn = 1'b0;
            end else if (sFall) begin
               next_so = outReg[127];
               next_soEn = 1'b1;
               next_outReg = {outReg[126:0], 1'b0};
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= ST_IDLE;
         bitCnt <= 7'd0;
         shiftIn <= 32'h0;
         opcode <= 8'h00;
         outReg <= 128'h0;
         so <= 1'b0;
         soEn <= 1'b0;
         writeEnableLatch <= 1'b0;
         erasePulse <= 1'b0;
         eraseBase <= 24'h0;
         eraseKind <= 4'h0;
         erasedSec <= 3'b000;
         readByte <= 8'h00;
         writeInProgress <= 1'b0;
      end else begin
         state <= next_state;
         bitCnt <= next_bitCnt;
         shiftIn <= next_shiftIn;
         opcode <= next_opcode;
         outReg <= next_outReg;
         so <= next_so;
         soEn <= next_soEn;
         writeEnableLatch <= next_wel;
         erasePulse <= next_erasePulse;
         eraseBase <= next_eraseBase;
         eraseKind <= next_eraseKind;
         erasedSec <= next_erasedSec;
         readByte <= next_readByte;
         writeInProgress <= busy || timerStart;
      end
   end

   sfe_erase_timer #(
      .HALF_CYC(HALF_CYC),
      .FULL_CYC(FULL_CYC),
      .CHIP_CYC(CHIP_CYC),
      .SECT_CYC(SECT_CYC)
   ) u_timer (
      .clk(clk),
      .srst(srst),
      .start(timerStart),
      .kind(timerKind),
      .busy(busy),
      .done(done)
   );

   property p_wip_on_start;
      @(posedge clk) disable iff (srst) erasePulse |-> writeInProgress;
   endproperty
   a_wip_on_start: assert property (p_wip_on_start) else $error("busy flag missing at erase start");
   property p_wel_clear_done;
      @(posedge clk) disable iff (srst) done |=> !writeEnableLatch;
   endproperty
   a_wel_clear_done: assert property (p_wel_clear_done) else $error("latch still set after erase");
   property p_chip_guard;
      @(posedge clk) disable iff (srst) (erasePulse && eraseKind == ERASE_CHIP) |-> $past(chipAllowed(prot));
   endproperty
   a_chip_guard: assert property (p_chip_guard) else $error("chip erase under protection");
   property p_erase_needs_wel;
      @(posedge clk) disable iff (srst) erasePulse |-> $past(writeEnableLatch);
   endproperty
   a_erase_needs_wel: assert property (p_erase_needs_wel) else $error("erase without latch");
   property p_no_out_busy;
      @(posedge clk) disable iff (srst) $rose(soEn) |-> !$past(busy, 2) || opcode != OP_IDENTIFICATION_READ;
   endproperty
   a_no_out_busy: assert property (p_no_out_busy) else $error("id output while busy");
   property p_cs_ends_out;
      @(posedge clk) disable iff (srst) (state == ST_OUT && csRise) |=> !soEn;
   endproperty
   a_cs_ends_out: assert property (p_cs_ends_out) else $error("output not released");
   property p_wip_holds;
      @(posedge clk) disable iff (srst) (writeInProgress && !done) |=> writeInProgress;
   endproperty
   a_wip_holds: assert property (p_wip_holds) else $error("busy dropped early");
   property p_half_base;
      @(posedge clk) disable iff (srst) (erasePulse && eraseKind == ERASE_HALF) |-> eraseBase[14:0] == 15'h0;
   endproperty
   a_half_base: assert property (p_half_base) else $error("half block base misaligned");
   property p_full_base;
      @(posedge clk) disable iff (srst) (erasePulse && eraseKind == ERASE_FULL) |-> eraseBase[15:0] == 16'h0;
   endproperty
   a_full_base: assert property (p_full_base) else $error("full block base misaligned");
   property p_sel_held;
      @(posedge clk) disable iff (srst) (state == ST_IN && !csRise) |-> csLow;
   endproperty
   a_sel_held: assert property (p_sel_held) else $error("command state without select");
   property p_chip_bits;
      @(posedge clk) disable iff (srst) (erasePulse && eraseKind == ERASE_CHIP) |->
         $past(bitCnt) == 7'(OPCODE_BITS) && ($past(opcode) == OP_CHIP_ERASE_A || $past(opcode) == OP_CHIP_ERASE_B);
   endproperty
   a_chip_bits: assert property (p_chip_bits) else $error("chip erase with wrong bit count");
   property p_addr_bits;
      @(posedge clk) disable iff (srst) (erasePulse && eraseKind != ERASE_CHIP) |-> $past(bitCnt) == 7'(ADDR_END_BITS);
   endproperty
   a_addr_bits: assert property (p_addr_bits) else $error("addressed erase with wrong bit count");
   property p_block_guard;
      @(posedge clk) disable iff (srst) (erasePulse && (eraseKind == ERASE_HALF || eraseKind == ERASE_FULL)) |->
         !blockProtected(eraseBase, prot);
   endproperty
   a_block_guard: assert property (p_block_guard) else $error("protected block erased");
   property p_secure_addr;
      @(posedge clk) disable iff (srst) (erasePulse && eraseKind == ERASE_SECURE) |->
         eraseBase[23:16] == 8'h00 && eraseBase[11:10] == 2'b00 &&
         eraseBase[15:12] >= 4'h1 && eraseBase[15:12] <= 4'(SECURE_REG_COUNT);
   endproperty
   a_secure_addr: assert property (p_secure_addr) else $error("secure erase with bad address");
   property p_secure_lock;
      @(posedge clk) disable iff (srst) (erasePulse && eraseKind == ERASE_SECURE) |->
         !prot.secureRegLock[2'(eraseBase[13:12] - 2'd1)] && erasedSec[2'(eraseBase[13:12] - 2'd1)];
   endproperty
   a_secure_lock: assert property (p_secure_lock) else $error("locked secure register erased");
   property p_wip_done;
      @(posedge clk) disable iff (srst) done |=> !writeInProgress || erasePulse;
   endproperty
   a_wip_done: assert property (p_wip_done) else $error("busy flag kept after erase");
   // output cut by deselect, then quiet idle
   sequence s_out_cut;
      state == ST_OUT && csRise;
   endsequence
   sequence s_idle_quiet;
      state == ST_IDLE && !soEn;
   endsequence
   property p_cut_idle;
      @(posedge clk) disable iff (srst) s_out_cut |=> s_idle_quiet;
   endproperty
   a_cut_idle: assert property (p_cut_idle) else $error("no standby after deselect");
endmodule

// file: sim/sfe_host_model.sv
`timescale 1ns/10ps
module sfe_host_model (
   output logic csN,
   output logic sclk,
   output logic si,
   input wire logic clk,
   input wire logic so,
   input wire logic soEn
);
   localparam int HALF = 6;
   logic [127:0] got;
   logic sawEn;
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
      got = '0;
      sawEn = 1'b0;
   end
   // sends n bits msb first, then clocks in m bits, sclk idle low
   task automatic frame(input logic [63:0] tx, input int n, input int m);
      got = '0;
      sawEn = 1'b0;
      repeat (HALF) @(negedge clk);
      csN <= 1'b0;
      for (int i = 0; i < n + m; i++) begin
         si <= (i < n) ? tx[n - 1 - i] : ~si;
         repeat (HALF) @(negedge clk);
         if (i >= n) begin
            got = {got[126:0], so};
            sawEn = sawEn | soEn;
         end
         sclk <= 1'b1;
         repeat (HALF) @(negedge clk);
         sclk <= 1'b0;
      end
      repeat (HALF) @(negedge clk);
      // deselect right after the last bit; a released line shows the inverse
      csN <= 1'b1;
      si <= ~si;
   endtask
endmodule

// file: sim/test_serial_flash_erase_id_commands.sv
`timescale 1ns/10ps
module test_serial_flash_erase_id_commands;
   import sfe_pkg::*;
   localparam int HC = 40;
   localparam int FC = 50;
   localparam int CC = 1000;
   localparam int SC = 30;
   // id values are arbitrary
   localparam logic [7:0] MID = 8'ha5;
   localparam logic [7:0] DID = 8'h3c;
   localparam logic [7:0] MTY = 8'h42;
   localparam logic [7:0] CAP = 8'h17;
   localparam logic [127:0] UID = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic csN, sclk, si, so, soEn, writeInProgress, writeEnableLatch, erasePulse;
   logic [8:0] protIn = 9'h000;
   logic [7:0] readAddr = 8'h01;
   logic [23:0] eraseBase;
   logic [3:0] eraseKind;
   logic [7:0] readByte;
   int failures = 0;
   int n_tests = 0;

   always #2.5 clk = ~clk;

   sfe_host_model host_u (.csN(csN), .sclk(sclk), .si(si), .clk(clk), .so(so), .soEn(soEn));

   sfe_flash_cmd #(.MAKER_ID(MID), .DEVICE_ID(DID), .MEM_TYPE(MTY), .CAPACITY(CAP), .UNIQUE_ID(UID),
      .HALF_CYC(HC), .FULL_CYC(FC), .CHIP_CYC(CC), .SECT_CYC(SC)) dut_u (.clk(clk), .srst(srst),
      .csN(csN), .sclk(sclk), .si(si), .protIn(protIn), .readAddr(readAddr), .so(so), .soEn(soEn),
      .writeInProgress(writeInProgress), .writeEnableLatch(writeEnableLatch), .eraseBase(eraseBase),
      .eraseKind(eraseKind), .erasePulse(erasePulse), .readByte(readByte));

   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic write_enable_cmd;
      host_u.frame(OP_WRITE_ENABLE_CMD, 8, 0);
   endtask

   task automatic setp(input logic [8:0] p);
      @(negedge clk);
      protIn = p;
   endtask

   // len zero means the command must be dropped
   task automatic erase(input string what, input logic [63:0] tx, input int n, input logic [3:0] kind,
                        input logic [23:0] base, input int len, input logic write_enable_latch);
      int cnt;
      cnt = 0;
      host_u.frame(tx, n, 0);
      while (erasePulse !== 1'b1 && cnt < 12) begin
         @(negedge clk);
         cnt++;
      end
      check({what, " start"}, erasePulse, len != 0);
      if (len != 0) begin
         check({what, " kind"}, {writeInProgress, eraseKind}, {1'b1, kind});
         if (kind[1:0] != 2'b00)
            check({what, " base"}, eraseBase, base);
         cnt = 0;
         while (writeInProgress === 1'b1 && cnt < 3000) begin
            @(negedge clk);
            cnt++;
         end
         check({what, " span"}, cnt >= len - 2 && cnt <= len + 4, 1'b1);
      end else begin
         repeat (20) @(negedge clk);
         check({what, " idle"}, writeInProgress, 1'b0);
      end
      check({what, " latch"}, writeEnableLatch, write_enable_latch);
   endtask

   task automatic t_erases;
      write_enable_cmd();
      erase("half", {OP_HALF_BLOCK_ERASE, 24'h01_9abc}, 32, ERASE_HALF, 24'h01_8000, HC, 1'b0);
      write_enable_cmd();
      erase("full", {OP_FULL_BLOCK_ERASE, 24'h01_9abc}, 32, ERASE_FULL, 24'h01_0000, FC, 1'b0);
      write_enable_cmd();
      erase("chip60", OP_CHIP_ERASE_A, 8, ERASE_CHIP, 24'h0, CC, 1'b0);
      write_enable_cmd();
      erase("chipc7", OP_CHIP_ERASE_B, 8, ERASE_CHIP, 24'h0, CC, 1'b0);
      $display("erases done");
   endtask

   task automatic t_framing;
      erase("no latch", {OP_HALF_BLOCK_ERASE, 24'h00_0000}, 32, ERASE_HALF, 24'h0, 0, 1'b0);
      write_enable_cmd();
      erase("chip 9 bits", {OP_CHIP_ERASE_A, 1'b0}, 9, ERASE_CHIP, 24'h0, 0, 1'b1);
      erase("block 31 bits", {OP_FULL_BLOCK_ERASE, 23'h0}, 31, ERASE_FULL, 24'h0, 0, 1'b1);
      erase("block 33 bits", {OP_FULL_BLOCK_ERASE, 25'h0}, 33, ERASE_FULL, 24'h0, 0, 1'b1);
      $display("framing done");
   endtask

   task automatic t_protection;
      setp(9'h070);
      erase("prot block", {OP_FULL_BLOCK_ERASE, 24'h7f_0000}, 32, ERASE_FULL, 24'h0, 0, 1'b0);
      write_enable_cmd();
      erase("prot chip", OP_CHIP_ERASE_A, 8, ERASE_CHIP, 24'h0, 0, 1'b0);
      setp(9'h008);
      write_enable_cmd();
      erase("cmp only chip", OP_CHIP_ERASE_B, 8, ERASE_CHIP, 24'h0, 0, 1'b0);
      setp(9'h078);
      write_enable_cmd();
      erase("cmp chip", OP_CHIP_ERASE_A, 8, ERASE_CHIP, 24'h0, CC, 1'b0);
      setp(9'h000);
      $display("protection done");
   endtask

   task automatic t_secure;
      write_enable_cmd();
      erase("sec2", {OP_SECURE_ERASE, 24'h00_23ff}, 32, ERASE_SECURE, 24'h0, SC, 1'b0);
      @(negedge clk);
      readAddr = 8'h02;
      repeat (3) @(negedge clk);
      check("sec2 data", readByte, ERASED_BYTE);
      readAddr = 8'h03;
      repeat (3) @(negedge clk);
      check("sec3 data", readByte, 8'h00);
      write_enable_cmd();
      erase("sec bad sel", {OP_SECURE_ERASE, 24'h00_4000}, 32, ERASE_SECURE, 24'h0, 0, 1'b1);
      erase("sec bad top", {OP_SECURE_ERASE, 24'h01_1000}, 32, ERASE_SECURE, 24'h0, 0, 1'b1);
      setp(9'h007);
      erase("sec locked", {OP_SECURE_ERASE, 24'h00_1000}, 32, ERASE_SECURE, 24'h0, 0, 1'b0);
      setp(9'h000);
      $display("secure done");
   endtask

   task automatic t_ids;
      host_u.frame({OP_MAKER_DEVICE_ID_READ, 24'h0}, 32, 16);
      check("maker device", host_u.got[15:0], {MID, DID});
      host_u.frame(OP_IDENTIFICATION_READ, 8, 24);
      check("ident", host_u.got[23:0], {MID, MTY, CAP});
      host_u.frame(OP_IDENTIFICATION_READ, 8, 5);
      check("ident cut", host_u.got[4:0], MID[7:3]);
      repeat (10) @(negedge clk);
      check("so released", soEn, 1'b0);
      host_u.frame(OP_IDENTIFICATION_READ, 8, 8);
      check("ident again", host_u.got[7:0], MID);
      host_u.frame({OP_UNIQUE_ID_READ, 32'h0}, 40, 128);
      check("unique", host_u.got, UID);
      $display("ids done");
   endtask

   task automatic t_id_busy;
      realtime t0;
      int cnt;
      write_enable_cmd();
      host_u.frame(OP_CHIP_ERASE_A, 8, 0);
      t0 = $realtime;
      host_u.frame(OP_IDENTIFICATION_READ, 8, 24);
      check("busy id quiet", host_u.sawEn, 1'b0);
      check("busy kept", writeInProgress, 1'b1);
      cnt = 0;
      while (writeInProgress === 1'b1 && cnt < 3000) begin
         @(negedge clk);
         cnt++;
      end
      cnt = int'(($realtime - t0) / 5.0);
      check("busy span", cnt >= CC && cnt <= CC + 8, 1'b1);
      check("busy latch", writeEnableLatch, 1'b0);
      $display("id during erase done");
   endtask

   initial begin
      repeat (2) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      t_erases();
      t_framing();
      t_protection();
      t_secure();
      t_ids();
      t_id_busy();
      wrap_up();
   end

   initial begin
      #400000;
      failures++;
      wrap_up();
   end
endmodule
